// >>> rtl/felc_cfg.svh
/*
  constants of the fault event log counter bank: register indices,
  event counter count and first index, field layout, reset values and time base counts.
  assumes: included by bare name; definitions only.
*/
`ifndef FELC_CFG_SVH
`define FELC_CFG_SVH

// register indices (byte address is four times the index)
`define FELC_IDX_RUN_LO        8'h01
`define FELC_IDX_RUN_HI        8'h0B
`define FELC_IDX_RESET         8'h02
`define FELC_IDX_INT_ERR       8'h03
`define FELC_IDX_SHORT         8'h04
`define FELC_IDX_OVER_CUR      8'h05
`define FELC_IDX_UNDER_VOLT    8'h06
`define FELC_IDX_OVER_VOLT     8'h07
`define FELC_IDX_OVER_TEMP     8'h08
`define FELC_IDX_RESTORE_ERR   8'h09
`define FELC_IDX_STORE_ERR     8'h0A
`define FELC_IDX_IRQ_STATUS    8'h0C
`define FELC_IDX_IRQ_MASK      8'h0D

// number of event counters and their first index
`define FELC_NUM_EVT           9
`define FELC_IDX_EVT_BASE      8'h02

// field layout of the run time word split
`define FELC_RUN_LO_W          32
`define FELC_RUN_HI_W          16

// reset values
`define FELC_CNT_RST           16'h0000
`define FELC_RUN_RST           48'h0000_0000_0000
`define FELC_MASK_RST          9'h000

// time base: one millisecond at the reference clock
`define FELC_MS_NS             1000000
`define FELC_CLK_NS            4
`define FELC_MS_CYCLES         (`FELC_MS_NS / `FELC_CLK_NS)

`endif

// >>> rtl/felc_pkg.sv
/*
  types of the fault event log counter bank.
  assumes: constants come from felc_cfg.svh.
*/
package felc_pkg;

  // register port request bundle
  typedef struct packed {
    logic [9:0]  addr;   // byte address
    logic [31:0] wdata;  // write data, used only by the mask register
    logic        wr;     // write strobe
    logic        rd;     // read strobe
  } felc_req_t;

endpackage

// >>> rtl/felc_top.sv
/*
  fault event log counter bank: a 48-bit run time accumulator in
  milliseconds and nine saturating 16-bit event counters, read over a
  plain register port, with sticky event status and a masked interrupt.
  assumes: one clock, event inputs synchronous to it, synchronous reset.
*/
// Strobed register access and the register addresses were decided locally.
//
// Contract
// - 48-bit read-only millisecond run time counter
// - count drive resets, 16 bits, read-only
// - count internal drive errors, 16 bits
// - count output short circuits, 16 bits
// - count over-current events, 16 bits
// - count hardware under-voltage faults, 16 bits
// - count hardware over-voltage faults, 16 bits
// - count drive over-temperature faults, 16 bits
// - count parameter restore failures, 16 bits
// - count parameter store failures, 16 bits
`timescale 1ns/1ns
`include "felc_cfg.svh"

module felc_top #(
  parameter int MS_CYCLES = `FELC_MS_CYCLES  // clocks per millisecond
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // register port
  input  wire logic [9:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // fault indications, levels, one bit per counter
  input  wire logic [8:0]  FAULT,
  // interrupt
  output logic             IRQ
);

  localparam int NE = `FELC_NUM_EVT;  // event counter count

  // all properties run on the one clock and, except reset_clear_a, are muted while in reset
  default clocking cb_main @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  // register request bundle
  felc_pkg::felc_req_t req;
  assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // decode a byte address into a register index, misaligned gives zero
  function automatic logic [7:0] idx_of(input logic [9:0] a);
    idx_of = (a[1:0] == 2'h0) ? a[9:2] : 8'h00;
  endfunction

  // millisecond prescaler
  logic [31:0] ms_cnt_q;        // clocks into current millisecond
  logic        ms_tick;         // one-cycle pulse per millisecond
  assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));

  // prescaler runs freely from reset
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      ms_cnt_q <= 32'h0000_0000;
    else if (ms_tick)
      ms_cnt_q <= 32'h0000_0000;
    else
      ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
  end

  // run time accumulator
  logic [47:0] run_q;  // milliseconds since reset

  // saturates too, though 2^48 ms is far beyond any drive's life
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      run_q <= `FELC_RUN_RST;
    else if (ms_tick && run_q != 48'hFFFF_FFFF_FFFF)
      run_q <= run_q + 48'h0000_0000_0001;
  end

  // edge detection of fault levels
  logic [NE-1:0] fault_q;  // fault levels one cycle ago
  logic [NE-1:0] rise;     // one-cycle rising edge per fault
  assign rise = FAULT & ~fault_q;

  // previous level; cleared at reset so a fault held over reset counts
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      fault_q <= '0;
    else
      fault_q <= FAULT;
  end

  // event counters, one per fault input
  logic [15:0] cnt_q [NE];  // saturating counters

  generate
    for (genvar i = 0; i < NE; i++)
    begin : g_cnt
      // counters ..index i maps to bit i of FAULT
      always_ff @(posedge REF_CLK)
      begin
        if (RST)
          cnt_q[i] <= `FELC_CNT_RST;
        else if (rise[i] && cnt_q[i] != 16'hFFFF)
          cnt_q[i] <= cnt_q[i] + 16'h0001;
      end
    end
  endgenerate

  // decoded request
  logic [7:0] idx;   // register index of this cycle
  assign idx = idx_of(req.addr);

  logic rd_status;   // read of status register, which clears it
  assign rd_status = req.rd && idx == `FELC_IDX_IRQ_STATUS;

  // sticky status and mask
  logic [NE-1:0] stat_q;  // sticky event flags
  logic [NE-1:0] mask_q;  // interrupt enables

  // a read clears, but a new edge in the same cycle wins
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      stat_q <= '0;
    else if (rd_status)
      stat_q <= rise;
    else
      stat_q <= stat_q | rise;
  end

  // mask is the only writable register; counters ignore writes
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      mask_q <= `FELC_MASK_RST;
    else if (req.wr && idx == `FELC_IDX_IRQ_MASK)
      mask_q <= req.wdata[NE-1:0];
  end

  // level interrupt from registered state
  assign IRQ = |(stat_q & mask_q);

  // read mux: data one cycle after the strobe, zero otherwise
  logic [31:0] rd_d;  // next read data
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (req.rd)
    begin
      if (idx == `FELC_IDX_RUN_LO)
        rd_d = run_q[31:0];
      else if (idx == `FELC_IDX_RUN_HI)
        rd_d = {16'h0000, run_q[47:32]};
      else if (idx == `FELC_IDX_IRQ_STATUS)
        rd_d = {23'h000000, stat_q};
      else if (idx == `FELC_IDX_IRQ_MASK)
        rd_d = {23'h000000, mask_q};
      else if (idx >= `FELC_IDX_EVT_BASE
               && idx < `FELC_IDX_EVT_BASE + 8'(NE))
        rd_d = {16'h0000, cnt_q[4'(idx - `FELC_IDX_EVT_BASE)]};
      // unmapped index reads as zero
    end
  end

  // read data register
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      RDATA <= 32'h0000_0000;
    else
      RDATA <= rd_d;
  end

  // assertions
  // each one watches a register or output that this module drives;
  // counters are spelled out per index rather than in a loop, so a
  // failure names the fault kind at once; the reset check is the one
  // property that is not muted in reset, since reset is what it guards

  // a fault level that stays high over two samples
  sequence held_fault_s;
    FAULT[3] ##1 FAULT[3];
  endsequence

  // a fresh short circuit edge while the counter has room
  sequence short_edge_s;
    rise[2] && cnt_q[2] != 16'hFFFF;
  endsequence

  // a read strobe aimed at the store error counter
  sequence store_read_s;
    req.rd && idx == `FELC_IDX_EVT_BASE + 8'h08;
  endsequence

  // run time steps by one on each millisecond tick
  // unless it already sits at all ones
  run_step_a: assert property (
    ms_tick && run_q != 48'hFFFF_FFFF_FFFF |=> run_q == $past(run_q) + 1)
    else $error("run time missed a millisecond");

  // between ticks the run time must not move
  // a stray increment would drift the lifetime total
  run_hold_a: assert property (
    !ms_tick |=> $stable(run_q))
    else $error("run time moved without tick");

  // reset event counter follows its edge
  // one step per edge, checked against the previous value
  rst_count_a: assert property (
    rise[0] && cnt_q[0] != 16'hFFFF
    |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001)
    else $error("reset counter missed an edge");

  // internal error counter follows its edge
  // same shape as the other counters, bit 1 of the fault bus
  err_count_a: assert property (
    rise[1] && cnt_q[1] != 16'hFFFF
    |=> cnt_q[1] == $past(cnt_q[1]) + 16'h0001)
    else $error("internal error counter missed");

  // short circuit counter follows its edge
  // built from the named edge sequence above
  short_count_a: assert property (
    short_edge_s |=> cnt_q[2] == $past(cnt_q[2]) + 16'h0001)
    else $error("short circuit counter missed");

  // over current counter follows its edge
  // bit 3 of the fault bus
  ovc_count_a: assert property (
    rise[3] && cnt_q[3] != 16'hFFFF
    |=> cnt_q[3] == $past(cnt_q[3]) + 16'h0001)
    else $error("over current counter missed");

  // under voltage counter follows its edge
  // bit 4 of the fault bus
  uv_count_a: assert property (
    rise[4] && cnt_q[4] != 16'hFFFF
    |=> cnt_q[4] == $past(cnt_q[4]) + 16'h0001)
    else $error("under voltage counter missed");

  // over voltage counter follows its edge
  // bit 5 of the fault bus
  ov_count_a: assert property (
    rise[5] && cnt_q[5] != 16'hFFFF
    |=> cnt_q[5] == $past(cnt_q[5]) + 16'h0001)
    else $error("over voltage counter missed");

  // over temperature counter follows its edge
  // bit 6 of the fault bus
  temp_count_a: assert property (
    rise[6] && cnt_q[6] != 16'hFFFF
    |=> cnt_q[6] == $past(cnt_q[6]) + 16'h0001)
    else $error("over temperature counter missed");

  // restore failure counter follows its edge
  // bit 7 of the fault bus
  restore_count_a: assert property (
    rise[7] && cnt_q[7] != 16'hFFFF
    |=> cnt_q[7] == $past(cnt_q[7]) + 16'h0001)
    else $error("restore error counter missed");

  // store failure counter follows its edge
  // bit 8 of the fault bus
  store_count_a: assert property (
    rise[8] && cnt_q[8] != 16'hFFFF
    |=> cnt_q[8] == $past(cnt_q[8]) + 16'h0001)
    else $error("store error counter missed");

  // a level held over two samples must not count again
  // the classic bug is counting levels, not edges
  held_once_a: assert property (
    held_fault_s |=> $stable(cnt_q[3]))
    else $error("held fault counted twice");

  // without an edge the reset counter stays put
  // guards against a counter that free runs
  quiet_rst_a: assert property (
    !rise[0] |=> $stable(cnt_q[0]))
    else $error("reset counter moved without edge");

  // a full under voltage counter stays full
  // unreachable in short runs, kept for formal tools
  sat_hold_a: assert property (
    cnt_q[4] == 16'hFFFF |=> cnt_q[4] == 16'hFFFF)
    else $error("counter wrapped");

  // store counter readback in the cycle after the strobe
  // built from the named read sequence above
  read_data_a: assert property (
    store_read_s |=> RDATA == {16'h0000, $past(cnt_q[8])})
    else $error("store error readback wrong");

  // low run time word readback
  // not latched with the high word, so it may tear at a carry
  run_lo_rd_a: assert property (
    req.rd && idx == `FELC_IDX_RUN_LO |=> RDATA == $past(run_q[31:0]))
    else $error("run time low word readback wrong");

  // high run time word readback
  // upper half of the read word is zero
  run_hi_rd_a: assert property (
    req.rd && idx == `FELC_IDX_RUN_HI
    |=> RDATA == {16'h0000, $past(run_q[47:32])})
    else $error("run time high word readback wrong");

  // read data are zero when no read was asked
  // the master may rely on a quiet bus between reads
  rd_idle_a: assert property (
    !req.rd |=> RDATA == 32'h0000_0000)
    else $error("read data not zero when idle");

  // misaligned addresses read as zero
  // idx_of folds them onto the unmapped index
  misalign_a: assert property (
    req.rd && req.addr[1:0] != 2'h0 |=> RDATA == 32'h0000_0000)
    else $error("misaligned read not zero");

  // indices above the mask read as zero
  // no alias of a counter may appear there
  unmapped_a: assert property (
    req.rd && idx > `FELC_IDX_IRQ_MASK |=> RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");

  // status readback shows the flags before the clear
  // the clear lands in the same edge that loads the data
  stat_rd_a: assert property (
    req.rd && idx == `FELC_IDX_IRQ_STATUS
    |=> RDATA == {23'h000000, $past(stat_q)})
    else $error("status readback wrong");

  // every edge leaves its status flag set
  // whether or not a clearing read came with it
  stat_set_a: assert property (
    |rise |=> (stat_q & $past(rise)) == $past(rise))
    else $error("status flag not set by edge");

  // a status read leaves only the flags of that cycle's edges
  // the set wins over the clear
  stat_clr_a: assert property (
    rd_status |=> stat_q == $past(rise))
    else $error("status read did not clear");

  // an unmasked edge raises the interrupt next cycle
  // any write in the same cycle is left out
  irq_set_a: assert property (
    |(rise & mask_q) && !req.wr |=> IRQ)
    else $error("interrupt missed an edge");

  // a mask write lands in the next cycle
  // only the low bits, one per counter, are kept
  mask_wr_a: assert property (
    req.wr && idx == `FELC_IDX_IRQ_MASK
    |=> mask_q == $past(req.wdata[NE-1:0]))
    else $error("mask write lost");

  // the mask moves only on its own write
  // writes elsewhere must not leak into it
  mask_hold_a: assert property (
    !(req.wr && idx == `FELC_IDX_IRQ_MASK) |=> $stable(mask_q))
    else $error("mask changed without write");

  // writes never touch the short circuit counter or the run time
  // both are read-only to the master
  ro_write_a: assert property (
    req.wr && rise == '0 && !ms_tick
    |=> $stable(cnt_q[2]) && $stable(run_q))
    else $error("write reached a read-only register");

  // prescaler stays inside one millisecond
  // a runaway count would stall the run time until the 32-bit prescaler wraps
  pre_bound_a: assert property (
    ms_cnt_q < 32'(MS_CYCLES))
    else $error("prescaler out of range");

  // reset clears run time, status, read data and interrupt
  // not muted in reset, since reset is what it checks
  reset_clear_a: assert property (disable iff (1'b0)
    RST |=> run_q == `FELC_RUN_RST && stat_q == '0
    && RDATA == 32'h0000_0000 && !IRQ)
    else $error("reset left state behind");

endmodule // felc_top

// >>> dv/felc_master.sv
/*
  network master model: one-cycle read and write strobes on the plain
  register port.
  assumes: tasks are called just after a rising edge of clk.
*/
`timescale 1ns/1ns
module felc_master (
  // clock
  input  wire logic        clk,
  // register port
  output logic      [9:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [31:0] rdata
);
  // idle bus at time zero
  initial
  begin
    addr = 10'h000;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // write: one cycle, the bank never stalls
  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
    addr <= {idx, 2'b00};
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read: data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] idx, output logic [31:0] q);
    addr <= {idx, 2'b00};
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // sample mid-cycle, where the registered data have settled
    @(negedge clk);
    q = rdata;
    @(posedge clk);
  endtask
endmodule // felc_master

// >>> dv/felc_top_tb.sv
/*
  self-checking bench of the fault event log counter bank.
  assumes: felc_cfg.svh on the include path, run time base shortened.
*/
`timescale 1ns/1ns
`include "felc_cfg.svh"
module felc_top_tb;
  localparam int MS = 10;              // shortened millisecond
  logic        ref_clk = 1'b0;         // 250 MHz
  logic        rst = 1'b1;             // synchronous reset
  logic [9:0]  addr;                   // register port
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [8:0]  fault = 9'h000;         // fault levels
  logic        irq;
  logic [31:0] q;                      // read scratch
  logic [31:0] a;
  int          errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #2 ref_clk = ~ref_clk;

  felc_top #(.MS_CYCLES(MS)) uut (.REF_CLK(ref_clk), .RST(rst),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .FAULT(fault), .IRQ(irq));

  felc_master mst (.clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));

  task automatic chk(input string n, input logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic close_out();
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one fault edge, held high so a level must not count again
  task automatic pulse(input int b);
    fault[b] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    fault[b] <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // counters and unmapped place read zero after reset
  task automatic t_reset();
    for (int i = 2; i <= 10; i++)
    begin
      mst.rd_reg(8'(i), q);
      chk("cnt_rst", 32'h0000_0000, q);
    end
    mst.rd_reg(8'h3F, q);
    chk("unmapped", 32'h0000_0000, q);
  endtask

  // every event once, with status, irq and read clear
  task automatic t_events();
    mst.wr_reg(`FELC_IDX_IRQ_MASK, 32'h0000_01FF);
    for (int b = 0; b < 9; b++)
    begin
      pulse(b);
      chk("irq_set", 32'h1, {31'h0, irq});
      mst.rd_reg(8'(2 + b), q);
      chk("cnt", 32'h1, q);
      mst.rd_reg(`FELC_IDX_IRQ_STATUS, q);
      chk("status", 32'h1 << b, q);
      chk("irq_clr", 32'h0, {31'h0, irq});
    end
    // masked event: counts but no interrupt
    mst.wr_reg(`FELC_IDX_IRQ_MASK, 32'h0000_0000);
    pulse(2);
    chk("irq_mask", 32'h0, {31'h0, irq});
    // write to a read-only counter is ignored
    mst.wr_reg(`FELC_IDX_SHORT, 32'h0000_FFFF);
    mst.rd_reg(`FELC_IDX_SHORT, q);
    chk("cnt_ro", 32'h2, q);
  endtask

  // run time advances once per shortened millisecond
  task automatic t_run();
    mst.rd_reg(`FELC_IDX_RUN_LO, a);
    repeat (98) @(posedge ref_clk);
    mst.rd_reg(`FELC_IDX_RUN_LO, q);
    chk("run_ms", 32'd10, q - a);
    mst.rd_reg(`FELC_IDX_RUN_HI, q);
    chk("run_hi", 32'h0, q);
  endtask

  // hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      close_out();
    end
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_events();
    t_run();
    close_out();
  end
endmodule // felc_top_tb
